// file: logic/aiobc_pkg.sv
// Package with register map, field positions, reset values and timing constants.
package aiobc_pkg;
	localparam int ADDR_W = 6;
	localparam logic [5:0] OFS_BOARD_CONTROL = 6'h00;
	localparam logic [5:0] OFS_INTERRUPT_CONTROL = 6'h04;
	localparam logic [5:0] OFS_INPUT_SAMPLE_PORT = 6'h08;
	localparam logic [5:0] OFS_INPUT_FIFO_CONTROL = 6'h0C;
	localparam logic [5:0] OFS_FIRST_RATE_DIVIDER = 6'h10;
	localparam logic [5:0] OFS_SECOND_RATE_DIVIDER = 6'h14;
	localparam logic [5:0] OFS_OUTPUT_SAMPLE_PORT = 6'h18;
	localparam logic [5:0] OFS_OUTPUT_FIFO_CONTROL = 6'h1C;
	localparam logic [5:0] OFS_TIMING_SOURCE_SELECT = 6'h20;
	localparam logic [5:0] OFS_PARALLEL_PORT = 6'h24;
	localparam logic [5:0] OFS_LOGIC_VERSION = 6'h28;
	localparam logic [5:0] OFS_CALIBRATION_VALUES = 6'h2C;
	localparam logic [31:0] RST_BOARD_CONTROL = 32'h00004060;
	localparam logic [31:0] RST_INTERRUPT_CONTROL = 32'h00000008;
	localparam logic [31:0] RST_INPUT_FIFO_CONTROL = 32'h00007FFE;
	localparam logic [31:0] RST_FIRST_RATE_DIVIDER = 32'h000107D0;
	localparam logic [31:0] RST_SECOND_RATE_DIVIDER = 32'h00000050;
	localparam logic [31:0] RST_OUTPUT_FIFO_CONTROL = 32'h00007FFE;
	localparam logic [31:0] RST_TIMING_SOURCE_SELECT = 32'h000002D2;
	localparam logic [31:0] RST_PARALLEL_PORT = 32'h00000000;
	localparam logic [31:0] RST_CALIBRATION_VALUES = 32'h00000000;
	// Writable mask of the board control word; bit 14 is status only.
	localparam logic [15:0] BCR_WMASK = 16'hBF77;
	localparam int BIT_OUT_BURST_EN = 9;
	localparam int BIT_OUT_SYNC = 11;
	localparam int BIT_IN_SYNC = 12;
	localparam int BIT_AUTOCAL = 13;
	localparam int BIT_CAL_PASS = 14;
	localparam int BIT_SOFT_REINIT = 15;
	localparam logic [1:0] SCAN_SRC_SOFT = 2'h3;
	localparam int SCAN_SRC_LSB = 2;
	localparam int CLOCK_HZ = 10_000_000;
	localparam int LOAD_TIME_MS = 3;
	localparam int LOGIC_CFG_TIME_MS = 300;
	localparam int INIT_TIME_MS = 3;
	localparam int LOAD_CYCLES = LOAD_TIME_MS * (CLOCK_HZ / 1000);
	localparam int LOGIC_CFG_CYCLES = LOGIC_CFG_TIME_MS * (CLOCK_HZ / 1000);
	localparam int INIT_CYCLES = INIT_TIME_MS * (CLOCK_HZ / 1000);
	localparam int OP_CYCLES = 16;
	localparam int CNT_W = 32;
endpackage : aiobc_pkg

// file: logic/aiobc_regs.sv
// Register bank of the analog I/O board with configuration sequencer.
//
// Operation
// - Only full 32-bit accesses; narrower byte enables are refused.
// - Decode only the low address bits of a sixteen-longword window.
// - All interrupt conditions are merged onto one request line.
// - DMA reads input data port and writes output data port.
// - Input port at 0x08 is read-only; output port 0x18 write-only.
// - Control register has sixteen bits; upper bits read zero.
// - Self-clearing command bits return to zero when the operation ends.
// - Bits 0-2 select input configuration, reset zero.
// - Bits 4-5 select voltage range, reset to highest.
// - Bit 6 selects offset binary coding, resets to one.
// - Bit 8 selects simultaneous output update, resets clear.
// - Bit 9 enables one-shot output burst mode.
// - Bit 10 enables continuous output looping.
// - Bit 11 launches one burst when burst mode enabled.
// - Bit 12 starts one scan when software trigger selected.
// - Bit 13 starts autocalibration, clears when finished.
// - Bit 14 high at reset and calibration start; stays on success.
// - Bit 15 reinitializes logic and restores register defaults.
// - Bus reset starts configuration from nonvolatile memory.
// - Every access is retried while bus configuration loads.
// - Load, configure, then soft_reinit within 3, 300, 3 ms.
// - Configuration ends with bus interrupts disabled.
// - Soft reinit finishes within 3 ms, leaves bus config alone.
`timescale 1ns/100ps
module aiobc_regs #(
	parameter int LOAD_CNT = aiobc_pkg::LOAD_CYCLES,
	parameter int LOGIC_CFG_CNT = aiobc_pkg::LOGIC_CFG_CYCLES,
	parameter int INIT_CNT = aiobc_pkg::INIT_CYCLES,
	parameter int OP_CNT = aiobc_pkg::OP_CYCLES
) (
	// Clock and bus reset.
	input wire logic CLOCK,
	input wire logic RESET,
	// Target access from the bus bridge.
	input wire logic REQ,
	input wire logic WRITE,
	input wire logic [5:0] ADDR,
	input wire logic [3:0] BYTE_EN,
	input wire logic [31:0] WDATA,
	output logic ACK,
	output logic RETRY,
	output logic ERROR,
	output logic [31:0] RDATA,
	// Sample data paths.
	input wire logic [31:0] IN_SAMPLE,
	output logic IN_SAMPLE_POP,
	output logic [31:0] OUT_SAMPLE,
	output logic OUT_SAMPLE_PUSH,
	// Operation outcomes and events.
	input wire logic CAL_OK,
	input wire logic [7:0] IRQ_EVENTS,
	// Control outputs.
	output logic [15:0] BOARD_CONTROL,
	output logic [31:0] TIMING_SOURCE,
	output logic BURST_START,
	output logic SCAN_START,
	output logic IRQ,
	output logic BUS_INT_ENABLE,
	output logic CONFIG_DONE
);
	typedef enum {CFG_LOAD, CFG_LOGIC, CFG_INIT, CFG_RUN} aiobc_cfg_e;
	typedef struct packed {
		aiobc_cfg_e cfg;
		logic [31:0] cnt;
		logic [15:0] board_control;
		logic [31:0] irq_ctl;
		logic [31:0] in_ctl;
		logic [31:0] rate_a;
		logic [31:0] rate_b;
		logic [31:0] out_ctl;
		logic [31:0] tsel;
		logic [31:0] pport;
		logic [31:0] calv;
		logic [7:0] burst_cnt;
		logic [7:0] scan_cnt;
		logic [7:0] cal_cnt;
		logic ack;
		logic retry;
		logic error;
		logic [31:0] rdata;
		logic pop;
		logic push;
		logic [31:0] odata;
		logic bstart;
		logic sstart;
		logic irq;
		logic bus_ie;
		logic done;
	} aiobc_state_s;

	// Arbitrary logic version value.
	localparam logic [31:0] LOGIC_VERSION = 32'h00000100;

	aiobc_state_s st;
	aiobc_state_s next_st;
	logic rd;
	logic wr;
	logic [31:0] rword;
	logic [15:0] kept;

	always_comb begin
		next_st = st;
		next_st.ack = 1'b0;
		next_st.retry = 1'b0;
		next_st.error = 1'b0;
		next_st.pop = 1'b0;
		next_st.push = 1'b0;
		next_st.bstart = 1'b0;
		next_st.sstart = 1'b0;
		rd = 1'b0;
		wr = 1'b0;
		rword = 32'h00000000;
		kept = 16'h0000;
		case (st.cfg)
			CFG_LOAD: begin
				if (st.cnt >= 32'(LOAD_CNT - 1)) begin
					next_st.cfg = CFG_LOGIC;
					next_st.cnt = 32'h00000000;
				end else begin
					next_st.cnt = st.cnt + 32'h00000001;
				end
			end
			CFG_LOGIC: begin
				if (st.cnt >= 32'(LOGIC_CFG_CNT - 1)) begin
					next_st.cfg = CFG_INIT;
					next_st.cnt = 32'h00000000;
				end else begin
					next_st.cnt = st.cnt + 32'h00000001;
				end
			end
			CFG_INIT: begin
				if (st.cnt >= 32'(INIT_CNT - 1)) begin
					next_st.cfg = CFG_RUN;
					next_st.cnt = 32'h00000000;
					next_st.done = 1'b1;
					next_st.board_control[aiobc_pkg::BIT_SOFT_REINIT] = 1'b0;
				end else begin
					next_st.cnt = st.cnt + 32'h00000001;
				end
			end
			CFG_RUN: begin
			end
			default: next_st.cfg = CFG_RUN;
		endcase
		if (st.burst_cnt != 8'h00) begin
			next_st.burst_cnt = st.burst_cnt - 8'h01;
			if (st.burst_cnt == 8'h01) begin
				next_st.board_control[aiobc_pkg::BIT_OUT_SYNC] = 1'b0;
			end
		end
		if (st.scan_cnt != 8'h00) begin
			next_st.scan_cnt = st.scan_cnt - 8'h01;
			if (st.scan_cnt == 8'h01) begin
				next_st.board_control[aiobc_pkg::BIT_IN_SYNC] = 1'b0;
			end
		end
		if (st.cal_cnt != 8'h00) begin
			next_st.cal_cnt = st.cal_cnt - 8'h01;
			if (st.cal_cnt == 8'h01) begin
				next_st.board_control[aiobc_pkg::BIT_AUTOCAL] = 1'b0;
				next_st.board_control[aiobc_pkg::BIT_CAL_PASS] = CAL_OK;
			end
		end
		next_st.irq = st.bus_ie && ((st.irq_ctl[7:0] & IRQ_EVENTS) != 8'h00);
		if (REQ && !st.ack && !st.retry && !st.error) begin
			if (st.cfg == CFG_LOAD) begin
				next_st.retry = 1'b1;
			end else if (BYTE_EN != 4'hF) begin
				next_st.error = 1'b1;
			end else begin
				next_st.ack = 1'b1;
				rd = !WRITE;
				wr = WRITE;
			end
		end
		case (ADDR & 6'h3C)
			aiobc_pkg::OFS_BOARD_CONTROL: rword = {16'h0000, st.board_control};
			aiobc_pkg::OFS_INTERRUPT_CONTROL: rword = st.irq_ctl;
			aiobc_pkg::OFS_INPUT_SAMPLE_PORT: rword = IN_SAMPLE;
			aiobc_pkg::OFS_INPUT_FIFO_CONTROL: rword = st.in_ctl;
			aiobc_pkg::OFS_FIRST_RATE_DIVIDER: rword = st.rate_a;
			aiobc_pkg::OFS_SECOND_RATE_DIVIDER: rword = st.rate_b;
			aiobc_pkg::OFS_OUTPUT_FIFO_CONTROL: rword = st.out_ctl;
			aiobc_pkg::OFS_TIMING_SOURCE_SELECT: rword = st.tsel;
			aiobc_pkg::OFS_PARALLEL_PORT: rword = st.pport;
			aiobc_pkg::OFS_LOGIC_VERSION: rword = LOGIC_VERSION;
			aiobc_pkg::OFS_CALIBRATION_VALUES: rword = st.calv;
			default: rword = 32'h00000000;
		endcase
		if (rd) begin
			next_st.rdata = rword;
			if ((ADDR & 6'h3C) == aiobc_pkg::OFS_INPUT_SAMPLE_PORT) begin
				next_st.pop = 1'b1;
			end
		end
		if (wr) begin
			case (ADDR & 6'h3C)
				aiobc_pkg::OFS_BOARD_CONTROL: begin
					// mode fields
					// Start from the completion-adjusted word so a finishing command
					// is not held set by a write in the same cycle.
					kept = next_st.board_control;
					next_st.board_control = (kept & ~aiobc_pkg::BCR_WMASK)
						| (WDATA[15:0] & aiobc_pkg::BCR_WMASK);
					// Commands in progress stay set until they complete.
					next_st.board_control[aiobc_pkg::BIT_OUT_SYNC] = kept[aiobc_pkg::BIT_OUT_SYNC];
					next_st.board_control[aiobc_pkg::BIT_IN_SYNC] = kept[aiobc_pkg::BIT_IN_SYNC];
					next_st.board_control[aiobc_pkg::BIT_AUTOCAL] = kept[aiobc_pkg::BIT_AUTOCAL];
					next_st.board_control[aiobc_pkg::BIT_SOFT_REINIT] =
						kept[aiobc_pkg::BIT_SOFT_REINIT];
					if (WDATA[aiobc_pkg::BIT_OUT_SYNC] && WDATA[aiobc_pkg::BIT_OUT_BURST_EN]
							&& st.burst_cnt == 8'h00) begin
						next_st.board_control[aiobc_pkg::BIT_OUT_SYNC] = 1'b1;
						next_st.burst_cnt = 8'(OP_CNT);
						next_st.bstart = 1'b1;
					end
					if (WDATA[aiobc_pkg::BIT_IN_SYNC] && st.scan_cnt == 8'h00
							&& st.tsel[aiobc_pkg::SCAN_SRC_LSB +: 2]
							== aiobc_pkg::SCAN_SRC_SOFT) begin
						next_st.board_control[aiobc_pkg::BIT_IN_SYNC] = 1'b1;
						next_st.scan_cnt = 8'(OP_CNT);
						next_st.sstart = 1'b1;
					end
					if (WDATA[aiobc_pkg::BIT_AUTOCAL] && st.cal_cnt == 8'h00) begin
						next_st.board_control[aiobc_pkg::BIT_AUTOCAL] = 1'b1;
						next_st.board_control[aiobc_pkg::BIT_CAL_PASS] = 1'b1;
						next_st.cal_cnt = 8'(OP_CNT);
					end
					if (WDATA[aiobc_pkg::BIT_SOFT_REINIT] && st.cfg == CFG_RUN) begin
						next_st.board_control = aiobc_pkg::RST_BOARD_CONTROL[15:0];
						next_st.board_control[aiobc_pkg::BIT_SOFT_REINIT] = 1'b1;
						next_st.irq_ctl = aiobc_pkg::RST_INTERRUPT_CONTROL;
						next_st.in_ctl = aiobc_pkg::RST_INPUT_FIFO_CONTROL;
						next_st.rate_a = aiobc_pkg::RST_FIRST_RATE_DIVIDER;
						next_st.rate_b = aiobc_pkg::RST_SECOND_RATE_DIVIDER;
						next_st.out_ctl = aiobc_pkg::RST_OUTPUT_FIFO_CONTROL;
						next_st.tsel = aiobc_pkg::RST_TIMING_SOURCE_SELECT;
						next_st.pport = aiobc_pkg::RST_PARALLEL_PORT;
						next_st.calv = aiobc_pkg::RST_CALIBRATION_VALUES;
						next_st.burst_cnt = 8'h00;
						next_st.scan_cnt = 8'h00;
						next_st.cal_cnt = 8'h00;
						next_st.cfg = CFG_INIT;
						next_st.cnt = 32'h00000000;
						next_st.done = 1'b0;
					end
				end
				aiobc_pkg::OFS_INTERRUPT_CONTROL: begin
					next_st.irq_ctl = WDATA;
					next_st.bus_ie = 1'b1;
				end
				aiobc_pkg::OFS_INPUT_FIFO_CONTROL: next_st.in_ctl = WDATA;
				aiobc_pkg::OFS_FIRST_RATE_DIVIDER: next_st.rate_a = WDATA;
				aiobc_pkg::OFS_SECOND_RATE_DIVIDER: next_st.rate_b = WDATA;
				aiobc_pkg::OFS_OUTPUT_SAMPLE_PORT: begin
					next_st.odata = WDATA;
					next_st.push = 1'b1;
				end
				aiobc_pkg::OFS_OUTPUT_FIFO_CONTROL: next_st.out_ctl = WDATA;
				aiobc_pkg::OFS_TIMING_SOURCE_SELECT: next_st.tsel = WDATA;
				aiobc_pkg::OFS_PARALLEL_PORT: next_st.pport = WDATA;
				aiobc_pkg::OFS_CALIBRATION_VALUES: next_st.calv = WDATA;
				default: begin
				end
			endcase
		end
	end

	always_ff @(posedge CLOCK) begin
		if (RESET) begin
			st <= '0;
			st.cfg <= CFG_LOAD;
			st.board_control <= aiobc_pkg::RST_BOARD_CONTROL[15:0];
			st.irq_ctl <= aiobc_pkg::RST_INTERRUPT_CONTROL;
			st.in_ctl <= aiobc_pkg::RST_INPUT_FIFO_CONTROL;
			st.rate_a <= aiobc_pkg::RST_FIRST_RATE_DIVIDER;
			st.rate_b <= aiobc_pkg::RST_SECOND_RATE_DIVIDER;
			st.out_ctl <= aiobc_pkg::RST_OUTPUT_FIFO_CONTROL;
			st.tsel <= aiobc_pkg::RST_TIMING_SOURCE_SELECT;
			st.pport <= aiobc_pkg::RST_PARALLEL_PORT;
			st.calv <= aiobc_pkg::RST_CALIBRATION_VALUES;
		end else begin
			st <= next_st;
		end
	end

	assign ACK = st.ack;
	assign RETRY = st.retry;
	assign ERROR = st.error;
	assign RDATA = st.rdata;
	assign IN_SAMPLE_POP = st.pop;
	assign OUT_SAMPLE = st.odata;
	assign OUT_SAMPLE_PUSH = st.push;
	assign BOARD_CONTROL = st.board_control;
	assign TIMING_SOURCE = st.tsel;
	assign BURST_START = st.bstart;
	assign SCAN_START = st.sstart;
	assign IRQ = st.irq;
	assign BUS_INT_ENABLE = st.bus_ie;
	assign CONFIG_DONE = st.done;
endmodule : aiobc_regs

// file: tb/aiobc_regs_monitor.sv
// Concurrent checks on the ports of the board control register bank.
`timescale 1ns/100ps
module aiobc_regs_monitor #(
	parameter int OP_CNT = 16
) (
	// Clock and reset.
	input wire logic CLOCK,
	input wire logic RESET,
	// Register access.
	input wire logic REQ,
	input wire logic WRITE,
	input wire logic [5:0] ADDR,
	input wire logic [3:0] BYTE_EN,
	input wire logic [31:0] WDATA,
	input wire logic ACK,
	input wire logic RETRY,
	input wire logic ERROR,
	input wire logic [31:0] RDATA,
	// Sample paths and control.
	input wire logic IN_SAMPLE_POP,
	input wire logic [31:0] OUT_SAMPLE,
	input wire logic OUT_SAMPLE_PUSH,
	input wire logic [7:0] IRQ_EVENTS,
	input wire logic [15:0] BOARD_CONTROL,
	input wire logic BURST_START,
	input wire logic IRQ,
	input wire logic BUS_INT_ENABLE,
	input wire logic CONFIG_DONE
);
	default clocking @(posedge CLOCK); endclocking
	default disable iff (RESET);
	logic [7:0] hold;
	// Counts how long the burst command bit has stayed set.
	always_ff @(posedge CLOCK) hold <= (RESET || !BOARD_CONTROL[11]) ? 8'h00 : hold + 8'h01;
	sequence s_release;
		$fell(RESET);
	endsequence
	sequence s_rd_ctl;
		ACK && !WRITE && ADDR == 6'h00;
	endsequence
	a_single_answer: assert property ($onehot0({ACK, RETRY, ERROR}))
		else $error("more than one answer");
	a_part_error: assert property (CONFIG_DONE && REQ && !ACK && !RETRY && !ERROR && BYTE_EN != 4'hF |=> ERROR)
		else $error("partial access not refused");
	a_retry_load: assert property (s_release ##0 REQ |-> ##[1:2] RETRY)
		else $error("no retry while loading");
	a_config_order: assert property (s_release |-> !CONFIG_DONE [*8] ##[1:12] CONFIG_DONE)
		else $error("configuration length wrong");
	a_reset_value: assert property (s_release |-> BOARD_CONTROL == 16'h4060 && !BUS_INT_ENABLE)
		else $error("reset state wrong");
	a_upper_zero: assert property (s_rd_ctl |-> RDATA[31:16] == 16'h0000)
		else $error("upper control bits not zero");
	a_burst_launch: assert property (ACK && WRITE && ADDR == 6'h00 && WDATA[11] && WDATA[9] && CONFIG_DONE |-> BURST_START)
		else $error("burst not launched");
	a_self_clear: assert property (hold <= OP_CNT + 1)
		else $error("burst bit did not clear");
	a_cal_start: assert property ($rose(BOARD_CONTROL[13]) |-> BOARD_CONTROL[14])
		else $error("pass flag not set at calibration start");
	a_sample_push: assert property (OUT_SAMPLE_PUSH |-> ACK && WRITE && ADDR == 6'h18 && OUT_SAMPLE == WDATA)
		else $error("bad output sample push");
	a_sample_pop: assert property (IN_SAMPLE_POP |-> ACK && !WRITE && ADDR == 6'h08)
		else $error("bad input sample pop");
	a_irq_cause: assert property (IRQ |-> $past(BUS_INT_ENABLE) && $past(IRQ_EVENTS) != 8'h00)
		else $error("request without cause");
endmodule : aiobc_regs_monitor

// file: tb/aiobc_sample_source.sv
// Model of the far-side input sample buffer and calibration outcome.
`timescale 1ns/100ps
module aiobc_sample_source (
	// Clock.
	input wire logic CLOCK,
	// Pop strobe and chosen calibration outcome.
	input wire logic IN_SAMPLE_POP,
	input wire logic CAL_GOOD,
	// Buffer head and calibration result.
	output logic [31:0] IN_SAMPLE,
	output logic CAL_OK
);
	logic [31:0] word = 32'h1234ABCD;
	always @(posedge CLOCK) if (IN_SAMPLE_POP) word <= {word[30:0], word[31] ^ word[21]};
	assign IN_SAMPLE = word;
	assign CAL_OK = CAL_GOOD;
endmodule : aiobc_sample_source

// file: tb/aio_board_control_regs_bench.sv
// Self-checking bench of the board control register bank.
`timescale 1ns/100ps
module aio_board_control_regs_bench;
	logic CLOCK = 1'b0, RESET = 1'b1, REQ = 1'b0, WRITE = 1'b0, CAL_GOOD = 1'b1;
	logic [5:0] ADDR = 6'h00;
	logic [3:0] BYTE_EN = 4'hF;
	logic [31:0] WDATA = 32'h0, seed = 32'h3207, r, RDATA, IN_SAMPLE, OUT_SAMPLE, TIMING_SOURCE;
	logic [7:0] IRQ_EVENTS = 8'h00;
	logic ACK, RETRY, ERROR, IN_SAMPLE_POP, OUT_SAMPLE_PUSH, CAL_OK, BURST_START, SCAN_START;
	logic IRQ, BUS_INT_ENABLE, CONFIG_DONE;
	logic [15:0] BOARD_CONTROL;
	logic [1:0] resp;
	logic [31:0] q[$];
	logic [5:0] ra[7] = '{6'h00, 6'h04, 6'h0C, 6'h10, 6'h14, 6'h20, 6'h30};
	logic [31:0] rv[7] = '{32'h4060, 32'h8, 32'h7FFE, 32'h107D0, 32'h50, 32'h2D2, 32'h0};
	int fails = 0, tests_run = 0, retries = 0, n, bursts = 0, scans = 0;
	always #50 CLOCK = ~CLOCK;
	aiobc_regs #(.LOAD_CNT(4), .LOGIC_CFG_CNT(8), .INIT_CNT(4), .OP_CNT(16)) dut_u (.CLOCK, .RESET,
		.REQ, .WRITE, .ADDR, .BYTE_EN, .WDATA, .ACK, .RETRY, .ERROR, .RDATA, .IN_SAMPLE,
		.IN_SAMPLE_POP, .OUT_SAMPLE, .OUT_SAMPLE_PUSH, .CAL_OK, .IRQ_EVENTS, .BOARD_CONTROL,
		.TIMING_SOURCE, .BURST_START, .SCAN_START, .IRQ, .BUS_INT_ENABLE, .CONFIG_DONE);
	aiobc_sample_source src_u (.CLOCK, .IN_SAMPLE_POP, .CAL_GOOD, .IN_SAMPLE, .CAL_OK);
	function automatic logic [31:0] xs();
		seed ^= seed << 13;
		seed ^= seed >> 17;
		seed ^= seed << 5;
		return seed;
	endfunction : xs
	task automatic chk(input logic [31:0] e, input logic [31:0] g);
		tests_run++;
		if (g !== e) begin
			fails++;
			$display("CHECK FAILED %0t expected %h got %h", $time, e, g);
		end
	endtask : chk
	// Holds the request through retries until it is accepted or refused.
	task automatic acc(input logic w, input logic [5:0] a, input logic [31:0] d, input logic [3:0] b);
		n = 0;
		@(negedge CLOCK);
		{REQ, WRITE, ADDR, WDATA, BYTE_EN} = {1'b1, w, a, d, b};
		do begin
			@(negedge CLOCK);
			n++;
			retries += int'(RETRY === 1'b1);
		end while (ACK !== 1'b1 && ERROR !== 1'b1 && n < 60);
		resp = {ACK, ERROR};
		if (n >= 60) fails++;
		{REQ, BYTE_EN} = {1'b0, 4'hF};
	endtask : acc
	task automatic rd(input logic [5:0] a, input logic [31:0] e);
		q.push_back(e);
		acc(1'b0, a, 32'h0, 4'hF);
	endtask : rd
	task automatic wr(input logic [5:0] a, input logic [31:0] d);
		acc(1'b1, a, d, 4'hF);
	endtask : wr
	task automatic wait_done();
		n = 0;
		while (CONFIG_DONE !== 1'b1 && n < 100) begin
			@(negedge CLOCK);
			n++;
		end
		chk(32'h1, 32'(CONFIG_DONE));
	endtask : wait_done
	task automatic stop_test();
		$display("fails=%0d tests_run=%0d", fails, tests_run);
		if (fails == 0 && tests_run > 0) begin
			$display("NO MISMATCHES");
		end else begin
			$display("MISMATCHES SEEN");
		end
		$finish;
	endtask : stop_test
	always @(negedge CLOCK) if (ACK === 1'b1 && WRITE === 1'b0 && q.size() > 0) chk(q.pop_front(), RDATA);
	// Counts launch pulses, each seen once at the falling edge.
	always @(negedge CLOCK) begin
		bursts += int'(BURST_START === 1'b1);
		scans += int'(SCAN_START === 1'b1);
	end
	initial begin
		repeat (2) @(negedge CLOCK);
		RESET = 1'b0;
		for (int i = 0; i < 7; i++) rd(ra[i], rv[i]);
		chk(32'h1, 32'(retries > 0));
		wait_done();
		repeat (4) begin
			r = xs() & 32'hFFFF0577;
			wr(6'h00, r);
			rd(6'h00, (r & 32'h0577) | 32'h4000);
		end
		r = xs();
		wr(6'h18, r);
		chk(r, OUT_SAMPLE);
		wr(6'h08, r);
		rd(6'h08, src_u.word);
		acc(1'b1, 6'h00, 32'hFFFF, 4'h3);
		chk(32'h1, 32'(resp === 2'b01));
		wr(6'h00, 32'h0A00);
		repeat (20) @(negedge CLOCK);
		rd(6'h00, 32'h4200);
		chk(32'h1, 32'(bursts));
		wr(6'h20, 32'h2DE);
		chk(32'h2DE, TIMING_SOURCE);
		wr(6'h00, 32'h1000);
		repeat (20) @(negedge CLOCK);
		rd(6'h00, 32'h4000);
		chk(32'h1, 32'(scans));
		CAL_GOOD = 1'b0;
		wr(6'h00, 32'h2000);
		repeat (20) @(negedge CLOCK);
		rd(6'h00, 32'h0);
		CAL_GOOD = 1'b1;
		wr(6'h00, 32'h2000);
		repeat (20) @(negedge CLOCK);
		rd(6'h00, 32'h4000);
		IRQ_EVENTS = 8'(xs()) | 8'h01;
		wr(6'h04, 32'h1);
		repeat (3) @(negedge CLOCK);
		chk(32'h1, 32'(IRQ));
		wr(6'h04, 32'h0);
		repeat (3) @(negedge CLOCK);
		chk(32'h0, 32'(IRQ));
		wr(6'h00, 32'h8144);
		repeat (2) @(negedge CLOCK);
		wait_done();
		rd(6'h00, 32'h4060);
		rd(6'h20, 32'h2D2);
		chk(32'h1, 32'(BUS_INT_ENABLE));
		RESET = 1'b1;
		@(negedge CLOCK);
		RESET = 1'b0;
		rd(6'h00, 32'h4060);
		chk(32'h0, 32'(BUS_INT_ENABLE));
		stop_test();
	end
	initial begin
		#(3000 * 100);
		fails++;
		stop_test();
	end
endmodule : aio_board_control_regs_bench
bind aiobc_regs aiobc_regs_monitor #(.OP_CNT(OP_CNT)) mon_u (.CLOCK, .RESET, .REQ, .WRITE, .ADDR,
	.BYTE_EN, .WDATA, .ACK, .RETRY, .ERROR, .RDATA, .IN_SAMPLE_POP, .OUT_SAMPLE, .OUT_SAMPLE_PUSH,
	.IRQ_EVENTS, .BOARD_CONTROL, .BURST_START, .IRQ, .BUS_INT_ENABLE, .CONFIG_DONE);
